// ---- design/exec_pkg.sv ----
package exec_pkg;

  // ----------------------------------------
  // operation selector from decode
  // ----------------------------------------
  typedef enum logic [3:0] {
    op_none = 4'h0,
    logical_shift_left_op = 4'h1,
    logical_shift_right_op = 4'h2,
    register_move_op = 4'h3,
    indirect_load_op = 4'h4,
    indirect_offset_op = 4'h5,
    bank_literal_op = 4'h6,
    page_literal_op = 4'h7,
    accumulator_literal_op = 4'h8,
    accumulator_store_op = 4'h9
  } op_t;

  // ----------------------------------------
  // pointer update codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    upd_pre_inc = 2'h0,
    upd_pre_dec = 2'h1,
    upd_post_inc = 2'h2,
    upd_post_dec = 2'h3
  } pointer_update_code_t;

  // ----------------------------------------
  // widths, reset values, addresses
  // ----------------------------------------
  localparam int unsigned data_w = 8;
  localparam int unsigned file_addr_w = 7;
  localparam int unsigned ptr_w = 16;
  localparam int unsigned bank_w = 5;
  localparam int unsigned page_w = 7;
  localparam int unsigned offset_w = 6;
  localparam logic [6:0] indirect_target0_addr = 7'h00;
  localparam logic [6:0] indirect_target1_addr = 7'h01;
  localparam logic [7:0] acc_reset = 8'h00;
  localparam logic [15:0] ptr_reset = 16'h0000;
  localparam logic [4:0] bank_reset = 5'h00;
  localparam logic [6:0] page_reset = 7'h00;
  localparam logic [7:0] data_zero = 8'h00;

  // ----------------------------------------
  // decoded instruction bundle
  // ----------------------------------------
  typedef struct packed {
    op_t op;                          // operation
    logic [6:0] file_addr;            // register operand f
    logic dest;                       // 0 accumulator, 1 register
    logic ptr_sel;                    // which indirect pointer
    pointer_update_code_t upd;        // pointer update code
    logic [7:0] literal;              // literal / signed offset in [5:0]
  } instr_t;

  // ----------------------------------------
  // data register file access
  // ----------------------------------------
  typedef struct packed {
    logic rd_en;
    logic wr_en;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mem_req_t;

  // ----------------------------------------
  // core flags
  // ----------------------------------------
  typedef struct packed {
    logic carry;
    logic zero;
  } flags_t;

endpackage

// ---- design/pointer_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
// effective address and pointer update for indirect loads
module pointer_unit (
  input wire logic [15:0] ptr,
  input wire exec_pkg::pointer_update_code_t upd,
  input wire logic offset_mode,
  input wire logic [5:0] offset,
  output logic [15:0] eff_addr,
  output logic [15:0] ptr_next
);

  logic [15:0] inc; // wraps at ffff
  logic [15:0] dec; // wraps at 0000
  logic [15:0] sext; // signed offset widened

  // ----------------------------------------
  // 16-bit arithmetic, carry out dropped on purpose
  // ----------------------------------------
  always_comb
  begin
    inc = 16'(ptr + 16'h0001);
    dec = 16'(ptr - 16'h0001);
    sext = {{10{offset[5]}}, offset};
    if (offset_mode)
    begin
      eff_addr = 16'(ptr + sext);
      ptr_next = ptr;
    end
    else
    begin
      unique case (upd)
        exec_pkg::upd_pre_inc:
        begin
          eff_addr = inc;
          ptr_next = inc;
        end
        exec_pkg::upd_pre_dec:
        begin
          eff_addr = dec;
          ptr_next = dec;
        end
        exec_pkg::upd_post_inc:
        begin
          eff_addr = ptr;
          ptr_next = inc;
        end
        exec_pkg::upd_post_dec:
        begin
          eff_addr = ptr;
          ptr_next = dec;
        end
      endcase
    end
  end

endmodule // pointer_unit
`default_nettype wire

// ---- design/shift_move_instruction_exec.sv ----
// Function
// - left shift: bit7 to carry, zero in
// - right shift: bit0 to carry, zero in
// - shift result to accumulator or register
// - move copies register to accumulator or itself
// - move updates zero flag
// - indirect load with four pointer update codes
// - offset load: pointer plus signed offset, unchanged
// - indirect target redirects through its pointer
// - 16-bit pointers wrap at both ends
// - bank literal load, five bits, flags kept
// - page literal load, seven bits, flags kept
// - accumulator literal load, one cycle, flags kept
// - accumulator store to register, flags kept
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module shift_move_instruction_exec (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire exec_pkg::instr_t instr,
  input wire logic instr_valid,
  input wire logic [7:0] mem_rdata,
  input wire logic ptr_wr_en,
  input wire logic ptr_wr_sel,
  input wire logic [15:0] ptr_wr_data,
  output exec_pkg::mem_req_t mem_req,
  output exec_pkg::flags_t flags,
  output logic [7:0] accumulator,
  output logic [4:0] bank_select_reg,
  output logic [6:0] program_counter_high_latch,
  output logic [15:0] indirect_pointer0,
  output logic [15:0] indirect_pointer1,
  output logic busy
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  // two phases: request a read, then use the returned data
  typedef enum logic [0:0] {
    st_idle = 1'b0,
    st_exec = 1'b1
  } state_t;

  state_t state_q; // phase of a read-modify instruction
  exec_pkg::instr_t held_q; // instruction under execution
  logic [15:0] addr_q; // resolved data address of held operand
  logic [7:0] acc_q; // accumulator
  logic carry_q; // carry flag
  logic zero_q; // zero flag
  logic [4:0] bank_q; // bank select
  logic [6:0] page_q; // program counter high latch
  logic [15:0] ptr_q [2]; // indirect pointers
  exec_pkg::mem_req_t req_q; // registered memory request

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // zero test shared by every flag-updating path
  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == exec_pkg::data_zero);
  endfunction

  // resolve a file address, redirecting indirect targets
  function automatic logic [15:0] resolve(input logic [6:0] f, input logic [15:0] p0,
                                          input logic [15:0] p1);
    if (f == exec_pkg::indirect_target0_addr)
      resolve = p0;
    else if (f == exec_pkg::indirect_target1_addr)
      resolve = p1;
    else
      resolve = {9'h000, f};
  endfunction

  // ----------------------------------------
  // datapath helpers
  // ----------------------------------------
  logic [7:0] shift_res; // shifter result
  logic shift_c; // shifter carry
  logic [15:0] eff_addr; // indirect effective address
  logic [15:0] ptr_next; // updated pointer
  logic [15:0] sel_ptr; // pointer chosen by the new instruction
  logic start; // a new instruction accepted this cycle
  logic needs_read; // instruction reads the register file first

  shift_unit u_shift (
    .operand(mem_rdata),
    .right(held_q.op == exec_pkg::logical_shift_right_op),
    .result(shift_res),
    .carry_out(shift_c)
  );

  pointer_unit u_ptr (
    .ptr(sel_ptr),
    .upd(instr.upd),
    .offset_mode(instr.op == exec_pkg::indirect_offset_op),
    .offset(instr.literal[5:0]),
    .eff_addr(eff_addr),
    .ptr_next(ptr_next)
  );

  always_comb
  begin
    sel_ptr = instr.ptr_sel ? ptr_q[1] : ptr_q[0];
    start = instr_valid && (state_q == st_idle);
    unique case (instr.op)
      exec_pkg::logical_shift_left_op,
      exec_pkg::logical_shift_right_op,
      exec_pkg::register_move_op,
      exec_pkg::indirect_load_op,
      exec_pkg::indirect_offset_op: needs_read = 1'b1;
      default: needs_read = 1'b0;
    endcase
  end

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  // read data arrives in the cycle the registered read strobe stands, so one stall cycle
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= st_idle;
    else if (start && needs_read)
      state_q <= st_exec;
    else
      state_q <= st_idle;
  end

  // capture instruction and its address
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      held_q <= '0;
      addr_q <= exec_pkg::ptr_reset;
    end
    else if (start)
    begin
      held_q <= instr;
      if (instr.op == exec_pkg::indirect_load_op || instr.op == exec_pkg::indirect_offset_op)
        addr_q <= eff_addr;
      else
        addr_q <= resolve(instr.file_addr, ptr_q[0], ptr_q[1]);
    end
  end

  // ----------------------------------------
  // register file requests
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      req_q <= '0;
    else
    begin
      req_q <= '0;
      if (start && needs_read)
      begin
        // read operand
        req_q.rd_en <= 1'b1;
        if (instr.op == exec_pkg::indirect_load_op || instr.op == exec_pkg::indirect_offset_op)
          req_q.addr <= eff_addr;
        else
          req_q.addr <= resolve(instr.file_addr, ptr_q[0], ptr_q[1]);
      end
      else if (start && instr.op == exec_pkg::accumulator_store_op)
      begin
        req_q.wr_en <= 1'b1;
        req_q.addr <= resolve(instr.file_addr, ptr_q[0], ptr_q[1]);
        req_q.wdata <= acc_q;
      end
      else if (state_q == st_exec && held_q.dest)
      begin
        // write back into the addressed register
        if (held_q.op == exec_pkg::logical_shift_left_op ||
            held_q.op == exec_pkg::logical_shift_right_op)
        begin
          req_q.wr_en <= 1'b1;
          req_q.addr <= addr_q;
          req_q.wdata <= shift_res;
        end
        else if (held_q.op == exec_pkg::register_move_op)
        begin
          req_q.wr_en <= 1'b1;
          req_q.addr <= addr_q;
          req_q.wdata <= mem_rdata;
        end
      end
    end
  end

  // ----------------------------------------
  // accumulator
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      acc_q <= exec_pkg::acc_reset;
    else if (start && instr.op == exec_pkg::accumulator_literal_op)
      acc_q <= instr.literal;
    else if (state_q == st_exec)
    begin
      unique case (held_q.op)
        exec_pkg::logical_shift_left_op,
        exec_pkg::logical_shift_right_op:
          if (!held_q.dest)
            acc_q <= shift_res;
        exec_pkg::register_move_op:
          if (!held_q.dest)
            acc_q <= mem_rdata;
        exec_pkg::indirect_load_op,
        exec_pkg::indirect_offset_op:
          acc_q <= mem_rdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  // literal loads and stores never reach here, so flags hold
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      carry_q <= 1'b0;
      zero_q <= 1'b0;
    end
    else if (state_q == st_exec)
    begin
      unique case (held_q.op)
        exec_pkg::logical_shift_left_op,
        exec_pkg::logical_shift_right_op:
        begin
          carry_q <= shift_c;
          zero_q <= is_zero(shift_res);
        end
        exec_pkg::register_move_op,
        exec_pkg::indirect_load_op,
        exec_pkg::indirect_offset_op:
          zero_q <= is_zero(mem_rdata);
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // bank and page latches
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bank_q <= exec_pkg::bank_reset;
      page_q <= exec_pkg::page_reset;
    end
    else if (start)
    begin
      if (instr.op == exec_pkg::bank_literal_op)
        bank_q <= instr.literal[4:0];
      if (instr.op == exec_pkg::page_literal_op)
        page_q <= instr.literal[6:0];
    end
  end

  // ----------------------------------------
  // indirect pointers
  // ----------------------------------------
  // an external pointer write loses to an instruction update
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ptr_q[0] <= exec_pkg::ptr_reset;
      ptr_q[1] <= exec_pkg::ptr_reset;
    end
    else if (start && instr.op == exec_pkg::indirect_load_op)
      ptr_q[instr.ptr_sel] <= ptr_next;
    else if (ptr_wr_en)
      ptr_q[ptr_wr_sel] <= ptr_wr_data;
  end

  // ----------------------------------------
  // outputs, all from flip-flops
  // ----------------------------------------
  assign mem_req = req_q;
  assign flags = '{carry: carry_q, zero: zero_q};
  assign accumulator = acc_q;
  assign bank_select_reg = bank_q;
  assign program_counter_high_latch = page_q;
  assign indirect_pointer0 = ptr_q[0];
  assign indirect_pointer1 = ptr_q[1];
  assign busy = state_q;

endmodule // shift_move_instruction_exec
`default_nettype wire

// ---- design/shift_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
// combinational shifter for both logical shifts
module shift_unit (
  input wire logic [7:0] operand,
  input wire logic right,
  output logic [7:0] result,
  output logic carry_out
);

  // ----------------------------------------
  // shift through carry, zero inserted
  // ----------------------------------------
  always_comb
  begin
    if (right)
    begin
      result = {1'b0, operand[7:1]};
      carry_out = operand[0];
    end
    else
    begin
      result = {operand[6:0], 1'b0};
      carry_out = operand[7];
    end
  end

endmodule // shift_unit
`default_nettype wire

// ---- dv/exec_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module exec_monitor (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire exec_pkg::instr_t instr,
  input wire logic instr_valid,
  input wire logic [7:0] mem_rdata,
  input wire exec_pkg::mem_req_t mem_req,
  input wire exec_pkg::flags_t flags,
  input wire logic [7:0] accumulator,
  input wire logic [4:0] bank_select_reg,
  input wire logic [6:0] program_counter_high_latch,
  input wire logic busy
);
  // ----
  // one clock domain
  // ----
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // taken with no read op finishing at the same edge
  sequence take_s(exec_pkg::op_t o);
    instr_valid && !busy && !$past(busy) && instr.op == o;
  endsequence
  // ----
  // assertions
  // ----
  lit_acc_a: assert property (take_s(exec_pkg::accumulator_literal_op) |=>
    accumulator == $past(instr.literal) && $stable(flags)) else $error("literal load wrong");
  bank_lit_a: assert property (take_s(exec_pkg::bank_literal_op) |=>
    bank_select_reg == $past(instr.literal[4:0]) && $stable(flags)) else $error("bank load wrong");
  page_lit_a: assert property (take_s(exec_pkg::page_literal_op) |=>
    program_counter_high_latch == $past(instr.literal[6:0]) && $stable(flags))
    else $error("page load wrong");
  // read data stand in the cycle after the take; results show one cycle later
  store_wr_a: assert property (
    take_s(exec_pkg::accumulator_store_op) ##0 instr.file_addr > 7'h01
    |=> mem_req.wr_en && mem_req.addr == {9'h000, $past(instr.file_addr)}
    && mem_req.wdata == $past(accumulator) && $stable(flags)) else $error("store wrong");
  move_rd_a: assert property (
    take_s(exec_pkg::register_move_op) ##0 instr.file_addr > 7'h01
    |=> mem_req.rd_en && busy && mem_req.addr == {9'h000, $past(instr.file_addr)})
    else $error("move read wrong");
  move_zero_a: assert property (take_s(exec_pkg::register_move_op) |-> ##2
    flags.zero == ($past(mem_rdata) == 8'h00)) else $error("move zero flag wrong");
  shl_acc_a: assert property (
    take_s(exec_pkg::logical_shift_left_op) ##0 !instr.dest |-> ##2
    flags.carry == $past(mem_rdata[7]) && accumulator == {$past(mem_rdata[6:0]), 1'b0})
    else $error("left shift wrong");
  shr_acc_a: assert property (
    take_s(exec_pkg::logical_shift_right_op) ##0 !instr.dest |-> ##2
    flags.carry == $past(mem_rdata[0]) && accumulator == {1'b0, $past(mem_rdata[7:1])})
    else $error("right shift wrong");
  shl_wb_a: assert property (
    take_s(exec_pkg::logical_shift_left_op) ##0 instr.dest |-> ##2
    mem_req.wr_en && mem_req.wdata == {$past(mem_rdata[6:0]), 1'b0})
    else $error("shift write-back wrong");
endmodule // exec_monitor
bind shift_move_instruction_exec exec_monitor exec_monitor_i (.sys_clk(sys_clk), .rst_n(rst_n),
  .instr(instr), .instr_valid(instr_valid), .mem_rdata(mem_rdata), .mem_req(mem_req),
  .flags(flags), .accumulator(accumulator), .bank_select_reg(bank_select_reg),
  .program_counter_high_latch(program_counter_high_latch), .busy(busy));
`default_nettype wire

// ---- dv/regfile_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----
// data register file behind the block, read answer in the strobe's own cycle
// ----
module regfile_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire exec_pkg::mem_req_t mem_req,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [65536]; // whole data space, preloaded by the bench
  logic [7:0] last_q; // last value read, source of the idle garbage
  // plain always: the bench also preloads mem from its own process
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      last_q <= 8'h00;
    else
    begin
      if (mem_req.rd_en)
        last_q <= mem[mem_req.addr];
      if (mem_req.wr_en)
        mem[mem_req.addr] <= mem_req.wdata;
    end
  end
  // the block consumes read data while its strobe stands, so answer then;
  // any other cycle shows garbage, so a stray sample is caught
  assign mem_rdata = mem_req.rd_en ? mem[mem_req.addr] : ~last_q;
endmodule // regfile_model
`default_nettype wire

// ---- dv/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ----
  // signals
  // ----
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  exec_pkg::instr_t instr = '0;
  logic instr_valid = 1'b0;
  logic [7:0] mem_rdata;
  logic ptr_wr_en = 1'b0;
  logic ptr_wr_sel = 1'b0;
  logic [15:0] ptr_wr_data = 16'h0000;
  exec_pkg::mem_req_t mem_req;
  exec_pkg::flags_t flags;
  logic [7:0] accumulator;
  logic [4:0] bank_select_reg;
  logic [6:0] program_counter_high_latch;
  logic [15:0] indirect_pointer0;
  logic [15:0] indirect_pointer1;
  logic busy;
  int err_total = 0;
  int comparisons = 0;
  // chained codes cross both ends of the pointer range
  logic [1:0] upd_tab [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
  logic [7:0] acc_tab [4] = '{8'h22, 8'h22, 8'h00, 8'h00};
  logic [15:0] ptr_tab [4] = '{16'hffff, 16'h0000, 16'hffff, 16'h0000};
  always #2.5 sys_clk = ~sys_clk;
  shift_move_instruction_exec shift_move_instruction_exec_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .instr(instr), .instr_valid(instr_valid), .mem_rdata(mem_rdata), .ptr_wr_en(ptr_wr_en),
    .ptr_wr_sel(ptr_wr_sel), .ptr_wr_data(ptr_wr_data), .mem_req(mem_req), .flags(flags),
    .accumulator(accumulator), .bank_select_reg(bank_select_reg),
    .program_counter_high_latch(program_counter_high_latch),
    .indirect_pointer0(indirect_pointer0), .indirect_pointer1(indirect_pointer1), .busy(busy));
  regfile_model regfile_model_i (.sys_clk(sys_clk), .rst_n(rst_n), .mem_req(mem_req),
    .mem_rdata(mem_rdata));
  // ----
  // tasks
  // ----
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one instruction, then wait out the longest answer (write-back two edges on)
  task automatic run(input exec_pkg::op_t op, input logic [6:0] f, input logic d,
    input logic sel, input logic [1:0] upd, input logic [7:0] lit);
    @(posedge sys_clk);
    instr <= '{op, f, d, sel, exec_pkg::pointer_update_code_t'(upd), lit};
    instr_valid <= 1'b1;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
  task automatic ld_ptr(input logic sel, input logic [15:0] v);
    @(posedge sys_clk);
    ptr_wr_en <= 1'b1;
    ptr_wr_sel <= sel;
    ptr_wr_data <= v;
    @(posedge sys_clk);
    ptr_wr_en <= 1'b0;
  endtask
  task automatic print_verdict();
    if (err_total == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    err_total++;
    print_verdict();
  end
  // ----
  // main sequence
  // ----
  initial
  begin
    regfile_model_i.mem[16'h0020] <= 8'h81;
    regfile_model_i.mem[16'h0021] <= 8'h80;
    regfile_model_i.mem[16'h0022] <= 8'h01;
    regfile_model_i.mem[16'h0023] <= 8'hc2;
    regfile_model_i.mem[16'h0024] <= 8'h00;
    regfile_model_i.mem[16'h0025] <= 8'h3c;
    regfile_model_i.mem[16'h0000] <= 8'h00;
    regfile_model_i.mem[16'hffff] <= 8'h22;
    regfile_model_i.mem[16'hfff0] <= 8'h77;
    regfile_model_i.mem[16'h002f] <= 8'h5e;
    regfile_model_i.mem[16'h0123] <= 8'h9c;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    run(exec_pkg::register_move_op, 7'h24, 1'b1, 1'b0, 2'h0, 8'h00);
    chk("flags", 16'h0001, 16'(flags));
    run(exec_pkg::accumulator_literal_op, 7'h00, 1'b0, 1'b0, 2'h0, 8'h5a);
    chk("acc", 16'h005a, 16'(accumulator));
    run(exec_pkg::bank_literal_op, 7'h00, 1'b0, 1'b0, 2'h0, 8'h1f);
    chk("bank", 16'h001f, 16'(bank_select_reg));
    run(exec_pkg::page_literal_op, 7'h00, 1'b0, 1'b0, 2'h0, 8'h7f);
    chk("page", 16'h007f, 16'(program_counter_high_latch));
    chk("flags", 16'h0001, 16'(flags));
    run(exec_pkg::logical_shift_left_op, 7'h20, 1'b1, 1'b0, 2'h0, 8'h00);
    chk("mem20", 16'h0002, 16'(regfile_model_i.mem[16'h0020]));
    chk("flags", 16'h0002, 16'(flags));
    run(exec_pkg::logical_shift_left_op, 7'h21, 1'b0, 1'b0, 2'h0, 8'h00);
    chk("acc", 16'h0000, 16'(accumulator));
    chk("flags", 16'h0003, 16'(flags));
    run(exec_pkg::logical_shift_right_op, 7'h23, 1'b1, 1'b0, 2'h0, 8'h00);
    chk("mem23", 16'h0061, 16'(regfile_model_i.mem[16'h0023]));
    chk("flags", 16'h0000, 16'(flags));
    run(exec_pkg::logical_shift_right_op, 7'h22, 1'b0, 1'b0, 2'h0, 8'h00);
    chk("acc", 16'h0000, 16'(accumulator));
    chk("flags", 16'h0003, 16'(flags));
    run(exec_pkg::register_move_op, 7'h25, 1'b0, 1'b0, 2'h0, 8'h00);
    chk("acc", 16'h003c, 16'(accumulator));
    chk("flags", 16'h0002, 16'(flags));
    run(exec_pkg::accumulator_literal_op, 7'h00, 1'b0, 1'b0, 2'h0, 8'h4f);
    run(exec_pkg::accumulator_store_op, 7'h33, 1'b0, 1'b0, 2'h0, 8'h00);
    chk("mem33", 16'h004f, 16'(regfile_model_i.mem[16'h0033]));
    chk("flags", 16'h0002, 16'(flags));
    ld_ptr(1'b1, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      run(exec_pkg::indirect_load_op, 7'h00, 1'b0, 1'b1, upd_tab[i], 8'h00);
      chk("acc", 16'(acc_tab[i]), 16'(accumulator));
      chk("zero", 16'(acc_tab[i] == 8'h00), 16'(flags.zero));
      chk("ptr1", ptr_tab[i], indirect_pointer1);
    end
    ld_ptr(1'b0, 16'h0010);
    run(exec_pkg::indirect_offset_op, 7'h00, 1'b0, 1'b0, 2'h0, 8'h20);
    chk("acc", 16'h0077, 16'(accumulator));
    run(exec_pkg::indirect_offset_op, 7'h00, 1'b0, 1'b0, 2'h0, 8'h1f);
    chk("acc", 16'h005e, 16'(accumulator));
    chk("ptr0", 16'h0010, indirect_pointer0);
    ld_ptr(1'b0, 16'h0123);
    run(exec_pkg::register_move_op, 7'h00, 1'b0, 1'b0, 2'h0, 8'h00);
    chk("acc", 16'h009c, 16'(accumulator));
    run(exec_pkg::accumulator_store_op, 7'h01, 1'b0, 1'b0, 2'h0, 8'h00);
    chk("mem0", 16'h009c, 16'(regfile_model_i.mem[16'h0000]));
    print_verdict();
  end
endmodule // tb
`default_nettype wire
